// ==== verilog/mft2_top.sv ====
// Second multi-function timer: APB registers, prescaler, counter, flags and port read select.
//
// Notes on behaviour
// - Port read returns pins or data registers.
// - Read mode never touches the timer.
// - Capture edge bit picks rising or falling.
// - Event edge bit picks rising or falling.
// - Prescaler divides clock by two to code.
// - Mode field picks timer, PWM, capture, event.
// - Compare enable gates compare match interrupts.
// - Overflow enable gates overflow interrupts.
`timescale 1ns/1ps
`default_nettype none
module mft2_top
  import mft2_pkg::*;
#(
  parameter int CNT_W  = 16,
  parameter int PORT_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Timer pins
  input  wire logic              capture_one_pin,
  input  wire logic              capture_two_pin,
  input  wire logic              event_pin,
  output logic                   pwm_out,
  // Port read path
  input  wire logic [PORT_W-1:0] port_pin_in,
  input  wire logic [PORT_W-1:0] port_data_in,
  output logic      [PORT_W-1:0] port_read_data,
  // Interrupt
  output logic                   irq
);

  // The counter and port widths must fit one bus word.
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt
    $error("CNT_W must lie between 2 and 32");
  end
  if (PORT_W < 1 || PORT_W > 32) begin : g_bad_port
    $error("PORT_W must lie between 1 and 32");
  end
  // The prescaler must reach the largest terminal count of its code field.
  if (PRE_W != (1 << PS_W) - 1) begin : g_bad_pre
    $error("PRE_W must be two to the power of PS_W, less one");
  end
  // Status bits go through the eight-bit sticky helper; the mask shares their width.
  if (IRQ_W > 8) begin : g_bad_irq
    $error("IRQ_W must not exceed 8");
  end
  // Every lane that the core reads must exist in the detector.
  if (EDGE_N <= EDGE_EVT || EDGE_N <= EDGE_CAP_TWO || EDGE_N <= EDGE_CAP_ONE) begin : g_bad_edge
    $error("EDGE_N must cover the capture and event lanes");
  end
  // The mode and prescale fields must not run into their neighbours.
  if (B_PS_LSB + PS_W > B_EVT_EDGE || B_MODE_LSB + MODE_W > B_PS_LSB) begin : g_bad_fields
    $error("Mode and prescale fields overlap their neighbours");
  end

  typedef struct packed {
    logic [7:0]        ctrl_a;
    logic [7:0]        ctrl_b;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  cmp_one;
    logic [CNT_W-1:0]  cmp_two;
    logic [CNT_W-1:0]  cap_one;
    logic [CNT_W-1:0]  cap_two;
    logic [PRE_W-1:0]  pre;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic [31:0]       rdata;
    logic              pwm;
    logic [PORT_W-1:0] pin_s1;
    logic [PORT_W-1:0] pin_s2;
    logic [PORT_W-1:0] port_rd;
  } mft2_state_t;

  localparam mft2_state_t STATE_RST = '{
    ctrl_a:     CTRL_A_RST,
    ctrl_b:     CTRL_B_RST,
    count:      '0,
    cmp_one:    '0,
    cmp_two:    '0,
    cap_one:    '0,
    cap_two:    '0,
    pre:        '0,
    irq_status: IRQ_RST,
    irq_mask:   IRQ_RST,
    rdata:      '0,
    pwm:        1'b0,
    pin_s1:     '0,
    pin_s2:     '0,
    port_rd:    '0
  };

  mft2_state_t st_reg;
  mft2_state_t st_next;

  // The detector owns the capture and event pin synchronisers, so the core never reads those pins raw.
  mft2_edge_if #(.N(EDGE_N)) edge_bus ();

  mft2_edge #(
    .N (EDGE_N)
  ) u_edge (
    .clk  (clk),
    .nrst (nrst),
    .bus  (edge_bus)
  );

  // Both capture lanes share one edge select, the event lane has its own.
  assign edge_bus.pins[EDGE_CAP_ONE]     = capture_one_pin;
  assign edge_bus.pins[EDGE_CAP_TWO]     = capture_two_pin;
  assign edge_bus.pins[EDGE_EVT]         = event_pin;
  assign edge_bus.rise_sel[EDGE_CAP_ONE] = st_reg.ctrl_b[B_CAP_EDGE];
  assign edge_bus.rise_sel[EDGE_CAP_TWO] = st_reg.ctrl_b[B_CAP_EDGE];
  assign edge_bus.rise_sel[EDGE_EVT]     = st_reg.ctrl_b[B_EVT_EDGE];

  // Widen a counter value to a read word.
  function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
    widen = 32'h0;
    widen[CNT_W-1:0] = v;
  endfunction

  // Only the offsets below are decoded; anything else answers with an error.
  function automatic logic addr_known(input logic [APB_AW-1:0] a);
    case (a)
      OFF_CTRL_A, OFF_CTRL_B, OFF_COUNT, OFF_CMP_ONE, OFF_CMP_TWO,
      OFF_CAP_ONE, OFF_CAP_TWO, OFF_IRQ_STATUS, OFF_IRQ_MASK: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  // A compare match counts only when the counter really moves onto the value.
  function automatic logic match_on_advance(input logic             step,
                                            input logic [CNT_W-1:0] next_v,
                                            input logic [CNT_W-1:0] cmp_v);
    match_on_advance = step && (next_v == cmp_v);
  endfunction

  // Capture edges only count in capture/compare mode.
  function automatic logic capture_seen(input mft2_mode_t m, input logic hit);
    capture_seen = (m == MODE_CAP_CMP) && hit;
  endfunction

  logic             acc;
  logic             wr;
  logic             rd_setup;
  mft2_mode_t       mode;
  logic             tick;
  logic             adv;
  logic             pwm_wrap;
  logic [CNT_W-1:0] cnt_after;
  logic             ovf_hit;
  logic             cmp_one_hit;
  logic             cmp_two_hit;
  logic             cap_one_hit;
  logic             cap_two_hit;
  logic [7:0]       flag_set;
  logic [7:0]       flag_clr;
  logic [7:0]       irq_set;
  logic [7:0]       irq_clr;
  logic [7:0]       irq_upd;

  always_comb begin
    st_next  = st_reg;
    acc      = psel && penable;
    wr       = acc && pwrite;
    rd_setup = psel && !penable && !pwrite;
    mode = mft2_mode_t'(st_reg.ctrl_b[B_MODE_LSB +: MODE_W]);

    // power of two prescale
    // At least, not equal: a smaller code written while the prescaler stands
    // above its new limit would otherwise stall the counter for a whole wrap.
    tick = (st_reg.pre >= mft2_pre_limit(st_reg.ctrl_b[B_PS_LSB +: PS_W]));
    st_next.pre = tick ? '0 : st_reg.pre + {{(PRE_W-1){1'b0}}, 1'b1};

    case (mode)
      MODE_EVENT: adv = edge_bus.pulse[EDGE_EVT];
      default:    adv = tick;
    endcase

    // PWM period ends at the second compare value instead of at full scale.
    pwm_wrap  = (mode == MODE_PWM) && (st_reg.count == st_reg.cmp_two);
    cnt_after = pwm_wrap ? '0 : st_reg.count + {{(CNT_W-1){1'b0}}, 1'b1};

    ovf_hit     = adv && !pwm_wrap && (&st_reg.count);
    cmp_one_hit = match_on_advance(adv, cnt_after, st_reg.cmp_one);
    cmp_two_hit = match_on_advance(adv, cnt_after, st_reg.cmp_two);
    cap_one_hit = capture_seen(mode, edge_bus.pulse[EDGE_CAP_ONE]);
    cap_two_hit = capture_seen(mode, edge_bus.pulse[EDGE_CAP_TWO]);

    if (adv) begin
      st_next.count = cnt_after;
    end
    // A capture keeps the count from before this edge's advance.
    if (cap_one_hit) begin
      st_next.cap_one = st_reg.count;
    end
    if (cap_two_hit) begin
      st_next.cap_two = st_reg.count;
    end
    // Registered, so the output lags the count by one clock but never glitches.
    st_next.pwm = (mode == MODE_PWM) && (st_reg.count < st_reg.cmp_one);

    flag_set = 8'h00;
    flag_set[A_OVF_F]     = ovf_hit;
    flag_set[A_CMP_ONE_F] = cmp_one_hit;
    flag_set[A_CMP_TWO_F] = cmp_two_hit;
    flag_set[A_CAP_ONE_F] = cap_one_hit;
    flag_set[A_CAP_TWO_F] = cap_two_hit;

    irq_set = 8'h00;
    irq_set[IRQ_OVF]     = ovf_hit && st_reg.ctrl_a[A_OVF_IE];
    irq_set[IRQ_CMP_ONE] = cmp_one_hit && st_reg.ctrl_a[A_CMP_IE];
    irq_set[IRQ_CMP_TWO] = cmp_two_hit && st_reg.ctrl_a[A_CMP_IE];
    irq_set[IRQ_CAP_ONE] = cap_one_hit && st_reg.ctrl_a[A_CAP_IE];
    irq_set[IRQ_CAP_TWO] = cap_two_hit && st_reg.ctrl_a[A_CAP_IE];

    flag_clr = 8'h00;
    irq_clr  = 8'h00;
    if (wr) begin
      case (paddr)
        OFF_CTRL_A: begin
          // Writing zero to a flag clears it; enable bits take the written value.
          flag_clr = ~pwdata[7:0] & A_FLAG_MASK;
          st_next.ctrl_a = (st_reg.ctrl_a & A_FLAG_MASK) | (pwdata[7:0] & ~A_FLAG_MASK);
        end
        OFF_CTRL_B:     st_next.ctrl_b = pwdata[7:0];
        // A software load of the counter overrides the advance in the same cycle.
        OFF_COUNT:      st_next.count = pwdata[CNT_W-1:0];
        OFF_CMP_ONE:    st_next.cmp_one = pwdata[CNT_W-1:0];
        OFF_CMP_TWO:    st_next.cmp_two = pwdata[CNT_W-1:0];
        OFF_IRQ_STATUS: irq_clr[IRQ_W-1:0] = pwdata[IRQ_W-1:0];
        OFF_IRQ_MASK:   st_next.irq_mask = pwdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    st_next.ctrl_a = mft2_sticky(st_next.ctrl_a, flag_set, flag_clr);
    irq_upd = mft2_sticky({{(8-IRQ_W){1'b0}}, st_reg.irq_status}, irq_set, irq_clr);
    st_next.irq_status = irq_upd[IRQ_W-1:0];

    // Read data is fetched in the setup cycle so that it comes from a flop.
    if (rd_setup) begin
      case (paddr)
        OFF_CTRL_A:     st_next.rdata = {24'h0, st_reg.ctrl_a};
        OFF_CTRL_B:     st_next.rdata = {24'h0, st_reg.ctrl_b};
        OFF_COUNT:      st_next.rdata = widen(st_reg.count);
        OFF_CMP_ONE:    st_next.rdata = widen(st_reg.cmp_one);
        OFF_CMP_TWO:    st_next.rdata = widen(st_reg.cmp_two);
        OFF_CAP_ONE:    st_next.rdata = widen(st_reg.cap_one);
        OFF_CAP_TWO:    st_next.rdata = widen(st_reg.cap_two);
        OFF_IRQ_STATUS: st_next.rdata = {27'h0, st_reg.irq_status};
        OFF_IRQ_MASK:   st_next.rdata = {27'h0, st_reg.irq_mask};
        default:        st_next.rdata = 32'h0;
      endcase
    end

    // Pin levels pass two stages first; the data registers share this clock.
    // port read source select
    st_next.pin_s1  = port_pin_in;
    st_next.pin_s2  = st_reg.pin_s1;
    st_next.port_rd = st_reg.ctrl_b[B_PORT_READ] ? port_data_in : st_reg.pin_s2;
    // read mode isolated from timer
    // The read mode bit feeds only the port path above; no timer term reads it,
    // so a pin forced against its driven level shows only in pin mode.
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Zero wait states: every access phase completes at its first edge.
  assign pready         = 1'b1;
  assign pslverr        = psel && penable && !addr_known(paddr);
  assign prdata         = st_reg.rdata;
  assign pwm_out        = st_reg.pwm;
  assign port_read_data = st_reg.port_rd;
  // A plain OR of flops, so the interrupt carries no glitch from the bus.
  assign irq            = |(st_reg.irq_status & st_reg.irq_mask);

endmodule
`default_nettype wire

// ==== verilog/mft2_pkg.sv ====
// Shared constants, register map and types of the second multi-function timer.
package mft2_pkg;

  // Register byte offsets on the APB.
  localparam int               APB_AW          = 8;
  localparam logic [APB_AW-1:0] OFF_CTRL_A     = 8'h00;
  localparam logic [APB_AW-1:0] OFF_CTRL_B     = 8'h04;
  localparam logic [APB_AW-1:0] OFF_COUNT      = 8'h08;
  localparam logic [APB_AW-1:0] OFF_CMP_ONE    = 8'h0c;
  localparam logic [APB_AW-1:0] OFF_CMP_TWO    = 8'h10;
  localparam logic [APB_AW-1:0] OFF_CAP_ONE    = 8'h14;
  localparam logic [APB_AW-1:0] OFF_CAP_TWO    = 8'h18;
  localparam logic [APB_AW-1:0] OFF_IRQ_STATUS = 8'h1c;
  localparam logic [APB_AW-1:0] OFF_IRQ_MASK   = 8'h20;

  // Flags and enables register fields.
  localparam int A_CAP_TWO_F = 7;
  localparam int A_CAP_ONE_F = 6;
  localparam int A_CAP_IE    = 5;
  localparam int A_CMP_TWO_F = 4;
  localparam int A_CMP_ONE_F = 3;
  localparam int A_CMP_IE    = 2;
  localparam int A_OVF_F     = 1;
  localparam int A_OVF_IE    = 0;
  localparam logic [7:0] A_FLAG_MASK = 8'hda;

  // Mode and prescale register fields.
  localparam int B_PORT_READ = 7;
  localparam int B_CAP_EDGE  = 6;
  localparam int B_EVT_EDGE  = 5;
  localparam int B_PS_LSB    = 2;
  localparam int PS_W        = 3;
  localparam int B_MODE_LSB  = 0;
  localparam int MODE_W      = 2;
  localparam int PRE_W       = 7;

  // Interrupt status and mask bits.
  localparam int IRQ_W       = 5;
  localparam int IRQ_OVF     = 0;
  localparam int IRQ_CMP_ONE = 1;
  localparam int IRQ_CMP_TWO = 2;
  localparam int IRQ_CAP_ONE = 3;
  localparam int IRQ_CAP_TWO = 4;

  // Reset values.
  localparam logic [7:0]       CTRL_A_RST = 8'h00;
  localparam logic [7:0]       CTRL_B_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST    = 5'h00;

  // Edge detector lanes.
  localparam int EDGE_N       = 3;
  localparam int EDGE_CAP_ONE = 0;
  localparam int EDGE_CAP_TWO = 1;
  localparam int EDGE_EVT     = 2;

  typedef enum logic [MODE_W-1:0] {
    MODE_SOFT_TIMER,
    MODE_PWM,
    MODE_CAP_CMP,
    MODE_EVENT
  } mft2_mode_t;

  // Terminal count of the prescaler: divide by two to the power of code.
  function automatic logic [PRE_W-1:0] mft2_pre_limit(input logic [PS_W-1:0] code);
    logic [PRE_W:0] one_hot;
    one_hot = {{PRE_W{1'b0}}, 1'b1} << code;
    mft2_pre_limit = one_hot[PRE_W-1:0] - {{(PRE_W-1){1'b0}}, 1'b1};
  endfunction

  // Sticky flag update; a set in the same cycle as a clear wins.
  function automatic logic [7:0] mft2_sticky(input logic [7:0] old_v,
                                             input logic [7:0] set_v,
                                             input logic [7:0] clr_v);
    mft2_sticky = (old_v & ~clr_v) | set_v;
  endfunction

endpackage

// ==== verilog/mft2_edge_if.sv ====
// Interface between the timer core and its pin edge detector.
`timescale 1ns/1ps
`default_nettype none
interface mft2_edge_if #(parameter int N = 3);
  logic [N-1:0] pins;
  logic [N-1:0] rise_sel;
  logic [N-1:0] pulse;

  modport det (input pins, input rise_sel, output pulse);
  modport user (output pins, output rise_sel, input pulse);
endinterface
`default_nettype wire

// ==== verilog/mft2_edge.sv ====
// Pin synchroniser and selectable edge detector for capture and event inputs.
`timescale 1ns/1ps
`default_nettype none
module mft2_edge
  import mft2_pkg::*;
#(
  parameter int N = EDGE_N
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins in, pulses out
  mft2_edge_if.det bus
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
  } mft2_edge_state_t;

  mft2_edge_state_t st_reg;
  mft2_edge_state_t st_next;

  // The first stage feeds only the second; edges are judged on the later two.
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = bus.pins;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.pulse = (bus.rise_sel & st_reg.s2 & ~st_reg.s3)
                   | (~bus.rise_sel & ~st_reg.s2 & st_reg.s3);

endmodule
`default_nettype wire

// ==== dv/mft2_top_assertions.sv ====
// Port-level checker of the second multi-function timer.
`timescale 1ns/1ps
`default_nettype none
module mft2_top_assertions
  import mft2_pkg::*;
#(
  parameter int CNT_W  = 16,
  parameter int PORT_W = 8
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Outputs watched, and the port data input
  input wire logic              pwm_out,
  input wire logic [PORT_W-1:0] port_data_in,
  input wire logic [PORT_W-1:0] port_read_data,
  input wire logic              irq
);
  logic [7:0]       b_q;
  logic [2:0]       en_q;
  logic [IRQ_W-1:0] mask_q;
  logic             apb_wr;
  logic             unmapped;
  assign apb_wr = psel && penable && pwrite;
  assign unmapped = !(paddr inside {OFF_CTRL_A, OFF_CTRL_B, OFF_COUNT, OFF_CMP_ONE,
    OFF_CMP_TWO, OFF_CAP_ONE, OFF_CAP_TWO, OFF_IRQ_STATUS, OFF_IRQ_MASK});

  // Shadow copies of the control fields, tracked from the bus writes alone.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      b_q <= 8'h00;
      en_q <= 3'h0;
      mask_q <= '0;
    end else if (apb_wr) begin
      if (paddr == OFF_CTRL_B) b_q <= pwdata[7:0];
      if (paddr == OFF_CTRL_A) en_q <= {pwdata[A_CAP_IE], pwdata[A_CMP_IE], pwdata[A_OVF_IE]};
      if (paddr == OFF_IRQ_MASK) mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_ready; pready == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_on; psel && penable && unmapped |-> pslverr; endproperty
  a_err_on: assert property (p_err_on) else $error("no error on unmapped access");
  property p_err_off; !(psel && penable) |-> !pslverr; endproperty
  a_err_off: assert property (p_err_off) else $error("error outside access phase");
  property p_port_data;
    b_q[B_PORT_READ] && $past(b_q[B_PORT_READ]) |-> port_read_data == $past(port_data_in);
  endproperty
  a_port_data: assert property (p_port_data) else $error("port read not data");
  property p_pwm_off; (b_q[1:0] != 2'b01) [*3] |-> !pwm_out; endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm out of mode");
  property p_irq_mask; irq |-> mask_q != '0; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
  property p_irq_hold; irq && !apb_wr |=> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  property p_irq_rise; $rose(irq) && !$past(apb_wr) |-> $past(en_q) != 3'h0; endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq with enables off");

  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_pwm: cover property ($rose(pwm_out));
endmodule

bind mft2_top mft2_top_assertions #(.CNT_W(CNT_W), .PORT_W(PORT_W)) u_chk (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out),
  .port_data_in(port_data_in), .port_read_data(port_read_data), .irq(irq));
`default_nettype wire

// ==== dv/multifunction_timer_two_control_tb.sv ====
// Self-checking bench of the second multi-function timer.
`timescale 1ns/1ps
`default_nettype none
module multifunction_timer_two_control_tb;
  import mft2_pkg::*;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic              clk, nrst, psel, penable, pwrite, pready, pslverr, ev;
  logic              cap_one, cap_two, evt, pwm_out, irq;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rv;
  logic [7:0]        pin_in, dat_in, prd;
  int                err_count, checks_done, n;

  mft2_top DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_one_pin(cap_one), .capture_two_pin(cap_two), .event_pin(evt),
    .pwm_out(pwm_out), .port_pin_in(pin_in), .port_data_in(dat_in),
    .port_read_data(prd), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  // An idle edge follows every transfer, so no strobe is driven twice in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv & m, e);
  endtask

  task automatic t_reset();
    rd(OFF_CTRL_A, ALL, 32'h0);
    rd(OFF_CTRL_B, ALL, 32'h0);
    rd(OFF_IRQ_STATUS, ALL, 32'h0);
    rd(OFF_IRQ_MASK, ALL, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk(ev, 32'h1);
    chk(rv, 32'h0);
    wr(OFF_CAP_ONE, 32'h1234);
    rd(OFF_CAP_ONE, ALL, 32'h0);
  endtask
  task automatic t_ovf();
    wr(OFF_CMP_ONE, 32'h9999);
    wr(OFF_CMP_TWO, 32'h9999);
    wr(OFF_IRQ_MASK, 32'h1f);
    wr(OFF_CTRL_A, 32'h01);
    wr(OFF_COUNT, 32'hfffc);
    wt(4);
    rd(OFF_CTRL_A, ALL, 32'h03);
    rd(OFF_IRQ_STATUS, ALL, 32'h01);
    chk(irq, 32'h1);
    wt(20);
    rd(OFF_CTRL_A, ALL, 32'h03);
    wr(OFF_CTRL_A, 32'h01);
    wr(OFF_IRQ_STATUS, 32'h01);
    chk(irq, 32'h0);
    rd(OFF_CTRL_A, ALL, 32'h01);
    wr(OFF_CTRL_A, 32'h00);
    wr(OFF_COUNT, 32'hfffc);
    wt(4);
    rd(OFF_CTRL_A, ALL, 32'h02);
    chk(irq, 32'h0);
  endtask
  task automatic t_cmp();
    wr(OFF_CMP_ONE, 32'h40);
    wr(OFF_CMP_TWO, 32'h80);
    wr(OFF_COUNT, 32'h0);
    wr(OFF_CTRL_A, 32'h04);
    wt(200);
    rd(OFF_CTRL_A, ALL, 32'h1c);
    rd(OFF_IRQ_STATUS, ALL, 32'h06);
    chk(irq, 32'h1);
    wr(OFF_IRQ_STATUS, 32'h06);
    chk(irq, 32'h0);
    wr(OFF_CTRL_A, 32'h00);
    wr(OFF_COUNT, 32'h30);
    wt(100);
    rd(OFF_CTRL_A, ALL, 32'h18);
    chk(irq, 32'h0);
  endtask
  // The two count samples lie exactly 8 divisions apart, so any tick phase gives 8.
  task automatic t_pre();
    for (int c = 0; c < 8; c++) begin
      wr(OFF_CTRL_B, (c << 2) | (c[0] ? 32'h80 : 32'h0));
      wr(OFF_COUNT, 32'h0);
      apb(1'b0, OFF_COUNT, 32'h0);
      n = rv;
      wt((8 << c) - 3);
      apb(1'b0, OFF_COUNT, 32'h0);
      chk(rv - n, 32'h8);
    end
  endtask
  task automatic t_cap();
    wr(OFF_CTRL_B, 32'h42);
    wr(OFF_CTRL_A, 32'h20);
    wr(OFF_COUNT, 32'h0);
    cap_one <= 1'b1;
    wt(8);
    rd(OFF_CTRL_A, 32'hc0, 32'h40);
    // The idle edge after the load and two synchroniser stages put the capture three counts on.
    rd(OFF_CAP_ONE, ALL, 32'h3);
    cap_two <= 1'b0;
    wt(8);
    rd(OFF_CTRL_A, 32'hc0, 32'h40);
    wr(OFF_CTRL_B, 32'h02);
    cap_two <= 1'b1;
    wt(8);
    rd(OFF_CTRL_A, 32'hc0, 32'h40);
    cap_two <= 1'b0;
    wt(8);
    rd(OFF_CTRL_A, 32'hc0, 32'hc0);
    rd(OFF_IRQ_STATUS, 32'h18, 32'h18);
    chk(irq, 32'h1);
    wr(OFF_CTRL_B, 32'h40);
    wr(OFF_CTRL_A, 32'h00);
    wr(OFF_IRQ_STATUS, 32'h18);
    cap_one <= 1'b0;
    wt(8);
    cap_one <= 1'b1;
    wt(8);
    rd(OFF_CTRL_A, 32'hc0, 32'h0);
    chk(irq, 32'h0);
  endtask
  task automatic t_evt();
    for (int s = 0; s < 2; s++) begin
      wr(OFF_CTRL_B, s ? 32'h03 : 32'h23);
      wr(OFF_COUNT, 32'h0);
      evt <= 1'b1;
      wt(8);
      rd(OFF_COUNT, ALL, s ? 32'h0 : 32'h1);
      evt <= 1'b0;
      wt(8);
      rd(OFF_COUNT, ALL, 32'h1);
    end
  endtask
  task automatic t_pwm();
    wr(OFF_CMP_ONE, 32'h4);
    wr(OFF_CMP_TWO, 32'h9);
    for (int m = 1; m >= 0; m--) begin
      wr(OFF_CTRL_B, m);
      wr(OFF_COUNT, 32'h0);
      wt(20);
      n = 0;
      repeat (20) begin
        @(posedge clk);
        if (pwm_out === 1'b1) n++;
      end
      chk(n, m ? 32'h8 : 32'h0);
    end
  endtask
  task automatic t_port();
    pin_in <= 8'ha5;
    dat_in <= 8'h3c;
    wt(6);
    chk(prd, 32'ha5);
    wr(OFF_CTRL_B, 32'h80);
    wt(3);
    chk(prd, 32'h3c);
  endtask

  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {cap_one, evt, pin_in, dat_in} = '0;
    cap_two = 1'b1;
    err_count = 0;
    checks_done = 0;
    wt(16);
    nrst <= 1'b1;
    wt(1);
    t_reset();
    t_ovf();
    t_cmp();
    t_pre();
    t_cap();
    t_evt();
    t_pwm();
    t_port();
    finish_test();
  end
  initial begin
    wt(30000);
    err_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
